// [verilog/stamp_consts.svh]
// Register offsets, field positions and reset values of the timestamp counter.
`ifndef STAMP_CONSTS_SVH
`define STAMP_CONSTS_SVH
// ----------------------------------------
// Control port offsets
// ----------------------------------------
`define OFS_COUNTER_CONTROL 12'h000
`define OFS_COUNTER_STATUS 12'h004
`define OFS_COUNT_LOW_RW 12'h008
`define OFS_COUNT_HIGH_RW 12'h00c
`define OFS_TICK_RATE_REPORT 12'h020
`define OFS_INTEGRATION_STATUS 12'hef8
`define OFS_INTEGRATION_CONTROL 12'hf00
`define OFS_IDENT_WORD_FOUR 12'hfd0
`define OFS_IDENT_WORD_FIVE 12'hfd4
`define OFS_IDENT_WORD_SIX 12'hfd8
// ----------------------------------------
// Read-only port offsets
// ----------------------------------------
`define OFS_COUNT_LOW_READONLY 12'h000
`define OFS_COUNT_HIGH_READONLY 12'h004
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define BIT_ENABLE 0
`define BIT_HALT_ON_DEBUG 1
`define BIT_DEBUG_HALT_FLAG 1
`define BIT_HALT_LATCH 0
`define BIT_RESTART_LATCH 1
`define BIT_INTEGRATION_MODE 0
`define IDENT_SIZE_FIELD 4'h0
`define ZERO_WORD 32'h0000_0000
`define ZERO_COUNT 64'h0000_0000_0000_0000
`define ONE_COUNT 64'h0000_0000_0000_0001
`endif

// [verilog/stamp_pkg.sv]
// Types shared by the timestamp counter design.
package stamp_pkg;
  typedef logic [31:0] word_t;
  typedef logic [63:0] count_t;
  typedef logic [11:0] offset_t;
endpackage : stamp_pkg

// [verilog/pin_sync.sv]
// Two-flop synchroniser for one input pin.
`timescale 1ns/1ns
module pin_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_out
);
  logic meta_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule : pin_sync

// [verilog/readonly_port.sv]
// Read-only register port that shows the live count.
`timescale 1ns/1ns
`include "stamp_consts.svh"
module readonly_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire stamp_pkg::offset_t paddr,
  input wire stamp_pkg::count_t count,
  output stamp_pkg::word_t prdata,
  output logic pready,
  output logic pslverr
);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Read data is registered during the setup phase so it stands in the access phase.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFS_COUNT_LOW_READONLY: prdata <= count[31:0]; // RULE21
        `OFS_COUNT_HIGH_READONLY: prdata <= count[63:32]; // RULE2
        default: prdata <= `ZERO_WORD;
      endcase
    end
  end
endmodule : readonly_port

// [verilog/stamp_counter.sv]
// 64-bit timestamp counter with a control port and a read-only port.
// Functional notes
// RULE1: status debug flag reads 0 when halted
// RULE2: read-only 0x0004 returns live high half
// RULE3: low-half write only stages the value
// RULE4: high-half write loads all 64 bits
// RULE5: software stops counter before high write
// RULE6: software writes low half before high
// RULE7: tick rate register stored, no effect
// RULE8: firmware programs tick rate in hertz
// RULE9: integration mode latches restart request
// RULE10: integration mode latches halt request
// RULE11: status read clears restart latch, clear wins
// RULE12: status read clears halt latch, clear wins
// RULE13: latches read zero outside integration mode
// RULE14: integration control bit 0 enters integration
// RULE15: integration control upper bits read zero
// RULE16: ident size field reads zero
// RULE17: ident word four holds continuation code
// RULE18: ident upper bits and words five, six zero
// RULE19: enable bit starts and stops counting
// RULE20: halt-on-debug lets halt request freeze count
// RULE21: read-only port offset 0 returns low half
// RULE22: counter increments and wraps each cycle
`timescale 1ns/1ns
`include "stamp_consts.svh"
module stamp_counter #(
  // Designer continuation code; the value is arbitrary.
  parameter logic [3:0] DESIGNER_CONT_CODE = 4'h0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic halt_req,
  input wire logic restart_req,
  input wire logic ctl_psel,
  input wire logic ctl_penable,
  input wire logic ctl_pwrite,
  input wire stamp_pkg::offset_t ctl_paddr,
  input wire stamp_pkg::word_t ctl_pwdata,
  output stamp_pkg::word_t ctl_prdata,
  output logic ctl_pready,
  output logic ctl_pslverr,
  input wire logic ro_psel,
  input wire logic ro_penable,
  input wire logic ro_pwrite,
  input wire stamp_pkg::offset_t ro_paddr,
  output stamp_pkg::word_t ro_prdata,
  output logic ro_pready,
  output logic ro_pslverr,
  output stamp_pkg::count_t count_value
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic halt_sync;
  logic restart_sync;

  pin_sync halt_pin (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(halt_req),
    .pin_out(halt_sync)
  );

  pin_sync restart_pin (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(restart_req),
    .pin_out(restart_sync)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_access;
  logic rd_setup;

  assign wr_access = ctl_psel && ctl_penable && ctl_pwrite;
  assign rd_setup = ctl_psel && !ctl_penable && !ctl_pwrite;
  assign ctl_pready = 1'b1;
  assign ctl_pslverr = 1'b0;

  // ----------------------------------------
  // Control and configuration registers
  // ----------------------------------------
  logic enable_q;
  logic halt_on_debug_bit_q;
  logic integration_mode_bit_q;
  stamp_pkg::word_t tick_rate_report_q;
  stamp_pkg::word_t count_low_stage_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
      halt_on_debug_bit_q <= 1'b0;
    end else if (wr_access && ctl_paddr == `OFS_COUNTER_CONTROL) begin
      enable_q <= ctl_pwdata[`BIT_ENABLE]; // RULE19
      halt_on_debug_bit_q <= ctl_pwdata[`BIT_HALT_ON_DEBUG]; // RULE20
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_rate_report_q <= `ZERO_WORD;
    end else if (wr_access && ctl_paddr == `OFS_TICK_RATE_REPORT) begin
      tick_rate_report_q <= ctl_pwdata; // RULE7
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      integration_mode_bit_q <= 1'b0;
    end else if (wr_access && ctl_paddr == `OFS_INTEGRATION_CONTROL) begin
      integration_mode_bit_q <= ctl_pwdata[`BIT_INTEGRATION_MODE]; // RULE14 RULE15
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_low_stage_q <= `ZERO_WORD;
    end else if (wr_access && ctl_paddr == `OFS_COUNT_LOW_RW) begin
      count_low_stage_q <= ctl_pwdata; // RULE3
    end
  end

  // ----------------------------------------
  // Debug halt state
  // ----------------------------------------
  // With halt-on-debug set, a halt request pulse freezes the count until a restart request or halt-on-debug is cleared.
  logic debug_halted_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      debug_halted_q <= 1'b0;
    end else if (!halt_on_debug_bit_q) begin
      debug_halted_q <= 1'b0; // RULE20
    end else if (halt_sync) begin
      debug_halted_q <= 1'b1; // RULE20
    end else if (restart_sync) begin
      debug_halted_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  stamp_pkg::count_t count_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `ZERO_COUNT;
    end else if (wr_access && ctl_paddr == `OFS_COUNT_HIGH_RW) begin
      count_q <= {ctl_pwdata, count_low_stage_q}; // RULE4
    end else if (enable_q && !debug_halted_q) begin
      count_q <= count_q + `ONE_COUNT; // RULE19 RULE22
    end
  end

  assign count_value = count_q;

  // ----------------------------------------
  // Integration request latches
  // ----------------------------------------
  logic halt_latch_bit_q;
  logic restart_latch_bit_q;
  logic status_read;

  assign status_read = rd_setup && ctl_paddr == `OFS_INTEGRATION_STATUS;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      halt_latch_bit_q <= 1'b0;
    end else if (status_read) begin
      halt_latch_bit_q <= 1'b0; // RULE12
    end else if (integration_mode_bit_q && halt_sync) begin
      halt_latch_bit_q <= 1'b1; // RULE10
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      restart_latch_bit_q <= 1'b0;
    end else if (status_read) begin
      restart_latch_bit_q <= 1'b0; // RULE11
    end else if (integration_mode_bit_q && restart_sync) begin
      restart_latch_bit_q <= 1'b1; // RULE9
    end
  end

  // ----------------------------------------
  // Control port read data
  // ----------------------------------------
  stamp_pkg::word_t rd_word;

  always_comb begin
    rd_word = `ZERO_WORD;
    unique case (ctl_paddr)
      `OFS_COUNTER_CONTROL: begin
        rd_word[`BIT_ENABLE] = enable_q;
        rd_word[`BIT_HALT_ON_DEBUG] = halt_on_debug_bit_q;
      end
      `OFS_COUNTER_STATUS: rd_word[`BIT_DEBUG_HALT_FLAG] = !debug_halted_q; // RULE1
      `OFS_COUNT_LOW_RW: rd_word = count_q[31:0]; // RULE3
      `OFS_COUNT_HIGH_RW: rd_word = count_q[63:32]; // RULE4
      `OFS_TICK_RATE_REPORT: rd_word = tick_rate_report_q; // RULE7
      `OFS_INTEGRATION_STATUS: begin
        rd_word[`BIT_HALT_LATCH] = integration_mode_bit_q && halt_latch_bit_q; // RULE13
        rd_word[`BIT_RESTART_LATCH] = integration_mode_bit_q && restart_latch_bit_q; // RULE13
      end
      `OFS_INTEGRATION_CONTROL: rd_word[`BIT_INTEGRATION_MODE] = integration_mode_bit_q; // RULE15
      `OFS_IDENT_WORD_FOUR: rd_word[7:0] = {`IDENT_SIZE_FIELD, DESIGNER_CONT_CODE}; // RULE16 RULE17
      default: rd_word = `ZERO_WORD; // RULE18
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_prdata <= `ZERO_WORD;
    end else if (rd_setup) begin
      ctl_prdata <= rd_word;
    end
  end

  // ----------------------------------------
  // Read-only port
  // ----------------------------------------
  readonly_port ro_port (
    .clock(clock),
    .rst_b(rst_b),
    .psel(ro_psel),
    .penable(ro_penable),
    .pwrite(ro_pwrite),
    .paddr(ro_paddr),
    .count(count_q),
    .prdata(ro_prdata),
    .pready(ro_pready),
    .pslverr(ro_pslverr)
  );
endmodule : stamp_counter

// [testbench/stamp_counter_chk.sv]
// Port-level assertions for the timestamp counter.
`timescale 1ns/1ns
module stamp_counter_chk #(
  parameter logic [3:0] DESIGNER_CONT_CODE = 4'h0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ctl_psel,
  input wire logic ctl_penable,
  input wire logic ctl_pwrite,
  input wire stamp_pkg::offset_t ctl_paddr,
  input wire stamp_pkg::word_t ctl_pwdata,
  input wire stamp_pkg::word_t ctl_prdata,
  input wire logic ro_psel,
  input wire logic ro_penable,
  input wire logic ro_pwrite,
  input wire stamp_pkg::offset_t ro_paddr,
  input wire stamp_pkg::word_t ro_prdata,
  input wire stamp_pkg::count_t count_value
);
  wire logic ctl_rd = ctl_psel && !ctl_penable && !ctl_pwrite;
  wire logic ro_rd = ro_psel && !ro_penable && !ro_pwrite;
  wire logic hi_wr = ctl_psel && ctl_penable && ctl_pwrite && ctl_paddr == 12'h00c;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_ro_low_live: assert property (ro_rd && ro_paddr == 12'h000 |=> ro_prdata == 32'($past(count_value)))
    else $error("read-only low half differs from count");
  chk_ro_high_live: assert property (ro_rd && ro_paddr == 12'h004 |=> {32'h0, ro_prdata} == ($past(count_value) >> 32))
    else $error("read-only high half differs from count");
  chk_ctl_low_read: assert property (ctl_rd && ctl_paddr == 12'h008 |=> ctl_prdata == 32'($past(count_value)))
    else $error("control low half differs from count");
  chk_high_write_load: assert property (hi_wr |=> count_value[63:32] == $past(ctl_pwdata))
    else $error("high write did not load count");
  chk_count_step_one: assert property (!hi_wr |=> $stable(count_value) || count_value == $past(count_value) + 64'h1)
    else $error("count moved by other than one");
  chk_itctl_upper_zero: assert property (ctl_rd && ctl_paddr == 12'hf00 |-> ##1 ctl_prdata[31:1] == 31'h0)
    else $error("mode control upper bits not zero");
  chk_integration_request_status_upper_zero: assert property (ctl_rd && ctl_paddr == 12'hef8 |=> ctl_prdata[31:2] == 30'h0)
    else $error("request status upper bits not zero");
  chk_ident_four_value: assert property (ctl_rd && ctl_paddr == 12'hfd0 |=> ctl_prdata == {28'h0, DESIGNER_CONT_CODE})
    else $error("ident word four wrong");
  chk_ident_five_six: assert property (ctl_rd && (ctl_paddr == 12'hfd4 || ctl_paddr == 12'hfd8) |=> ctl_prdata == 32'h0)
    else $error("ident words five or six not zero");
  chk_status_bit0_zero: assert property (ctl_rd && ctl_paddr == 12'h004 |=> !ctl_prdata[0])
    else $error("status bit zero set");
  cover property (hi_wr);
  cover property (ctl_rd && ctl_paddr == 12'hef8);
  cover property (ro_rd && ro_paddr == 12'h004);
endmodule : stamp_counter_chk

bind stamp_counter stamp_counter_chk #(.DESIGNER_CONT_CODE(DESIGNER_CONT_CODE)) chk_u (.clock, .rst_b, .ctl_psel,
  .ctl_penable, .ctl_pwrite, .ctl_paddr, .ctl_pwdata, .ctl_prdata, .ro_psel, .ro_penable, .ro_pwrite, .ro_paddr,
  .ro_prdata, .count_value);

// [testbench/tb_top.sv]
// Self-checking bench for the timestamp counter registers.
`timescale 1ns/1ns
module tb_top;
  // Arbitrary continuation code for this run.
  localparam logic [3:0] CODE = 4'h5;
  logic clock, rst_b, halt_req, restart_req, ctl_psel, ctl_penable, ctl_pwrite, ro_psel, ro_penable, ro_pwrite;
  logic ctl_pready, ctl_pslverr, ro_pready, ro_pslverr;
  stamp_pkg::offset_t ctl_paddr, ro_paddr;
  stamp_pkg::word_t ctl_pwdata, ctl_prdata, ro_prdata, q;
  stamp_pkg::count_t count_value, c1;
  int fails = 0;
  int compares = 0;
  stamp_counter #(.DESIGNER_CONT_CODE(CODE)) dut_u (.clock, .rst_b, .halt_req, .restart_req, .ctl_psel,
    .ctl_penable, .ctl_pwrite, .ctl_paddr, .ctl_pwdata, .ctl_prdata, .ctl_pready, .ctl_pslverr, .ro_psel,
    .ro_penable, .ro_pwrite, .ro_paddr, .ro_prdata, .ro_pready, .ro_pslverr, .count_value);
  // ----
  // Access tasks
  // ----
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic ro, input logic wr, input stamp_pkg::offset_t a, input stamp_pkg::word_t d);
    @(posedge clock);
    #1 ctl_psel = !ro;
    ro_psel = ro;
    ctl_pwrite = wr;
    ro_pwrite = wr;
    ctl_paddr = a;
    ro_paddr = a;
    ctl_pwdata = d;
    @(posedge clock);
    #1 ctl_penable = 1'b1;
    ro_penable = 1'b1;
    @(posedge clock);
    q = ro ? ro_prdata : ctl_prdata;
    #1 ctl_psel = 1'b0;
    ro_psel = 1'b0;
    ctl_penable = 1'b0;
    ro_penable = 1'b0;
  endtask : xfer
  task automatic rd(input logic ro, input stamp_pkg::offset_t a, input stamp_pkg::word_t e);
    xfer(ro, 1'b0, a, 32'h0);
    check(q, e);
  endtask : rd
  task automatic pulse(input logic h, input logic r);
    @(posedge clock);
    #1 halt_req = h;
    restart_req = r;
    @(posedge clock);
    #1 halt_req = 1'b0;
    restart_req = 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse
  task automatic dlt(input logic [63:0] e);
    @(posedge clock);
    #1 c1 = count_value;
    @(posedge clock);
    #1 check(count_value - c1, e);
  endtask : dlt
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----
  // Clock, watchdog and tests
  // ----
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst_b, halt_req, restart_req, ctl_psel, ctl_penable, ctl_pwrite, ro_psel, ro_penable, ro_pwrite} = 9'h0;
    ctl_paddr = 12'h0;
    ro_paddr = 12'h0;
    ctl_pwdata = 32'h0;
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    rd(0, 12'h000, 32'h0);
    rd(0, 12'h004, 32'h2);
    rd(0, 12'h008, 32'h0);
    rd(0, 12'h00c, 32'h0);
    rd(0, 12'h020, 32'h0);
    rd(0, 12'hef8, 32'h0);
    rd(0, 12'hf00, 32'h0);
    rd(0, 12'hfd0, {28'h0, CODE});
    rd(0, 12'hfd4, 32'h0);
    rd(0, 12'hfd8, 32'h0);
    rd(0, 12'h100, 32'h0);
    rd(1, 12'h000, 32'h0);
    rd(1, 12'h004, 32'h0);
    check({ctl_pready, ctl_pslverr, ro_pready, ro_pslverr}, 64'ha);
    $display("Test reset values done");
    xfer(0, 1, 12'h000, 32'h0);
    xfer(0, 1, 12'h008, 32'hffff_fffe);
    rd(0, 12'h008, 32'h0);
    xfer(0, 1, 12'h00c, 32'hffff_ffff);
    check(count_value, 64'hffff_ffff_ffff_fffe);
    xfer(1, 1, 12'h004, 32'h1234_5678);
    rd(1, 12'h004, 32'hffff_ffff);
    rd(1, 12'h000, 32'hffff_fffe);
    rd(0, 12'h00c, 32'hffff_ffff);
    $display("Test staged load done");
    xfer(0, 1, 12'h020, 32'h02fa_f080);
    rd(0, 12'h020, 32'h02fa_f080);
    xfer(0, 1, 12'h000, 32'h1);
    dlt(64'h1);
    check(count_value[63:32], 32'h0);
    xfer(0, 1, 12'h000, 32'h3);
    rd(0, 12'h000, 32'h3);
    pulse(1, 0);
    dlt(64'h0);
    rd(0, 12'h004, 32'h0);
    pulse(0, 1);
    dlt(64'h1);
    xfer(0, 1, 12'h000, 32'h1);
    pulse(1, 0);
    dlt(64'h1);
    rd(0, 12'h004, 32'h2);
    xfer(0, 1, 12'h000, 32'h0);
    dlt(64'h0);
    $display("Test counting done");
    xfer(0, 1, 12'hf00, 32'hffff_ffff);
    rd(0, 12'hf00, 32'h1);
    pulse(1, 0);
    rd(0, 12'hef8, 32'h1);
    rd(0, 12'hef8, 32'h0);
    pulse(0, 1);
    rd(0, 12'hef8, 32'h2);
    rd(0, 12'hef8, 32'h0);
    // Both requests reach the latches at the very edge of the next status read, so the clear must win.
    @(posedge clock);
    #1 halt_req = 1'b1;
    restart_req = 1'b1;
    @(posedge clock);
    #1 halt_req = 1'b0;
    restart_req = 1'b0;
    rd(0, 12'hef8, 32'h0);
    rd(0, 12'hef8, 32'h0);
    xfer(0, 1, 12'hf00, 32'h0);
    pulse(1, 1);
    rd(0, 12'hef8, 32'h0);
    $display("Test integration done");
    tally_and_finish();
  end
endmodule : tb_top
